// >>> hw/dma_channel_pkg.sv
package dma_channel_pkg;
  // register offsets, byte addresses
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_SOURCE = 8'h08;
  // control field positions
  localparam int POS_INDIRECT = 20;
  localparam int POS_SRC_STEP = 12;
  localparam int POS_REQ_SRC = 8;
  localparam int POS_SENSE = 6;
  localparam int POS_BUS_HOLD = 5;
  localparam int POS_UNIT = 3;
  localparam int POS_IRQ_EN = 2;
  localparam int POS_DONE = 1;
  localparam int POS_ENABLE = 0;
  // reset values
  localparam logic [1:0] RST_SRC_STEP = 2'h0;
  localparam logic [3:0] RST_REQ_SRC = 4'h0;
  localparam logic [1:0] RST_UNIT = 2'h0;
  localparam logic [23:0] RST_COUNT = 24'h00_0000;
  localparam logic [31:0] RST_SOURCE = 32'h0000_0000;
  localparam logic [31:0] RST_READ = 32'h0000_0000;
  // source step codes
  localparam logic [1:0] STEP_FIXED = 2'h0;
  localparam logic [1:0] STEP_UP = 2'h1;
  localparam logic [1:0] STEP_DOWN = 2'h2;
  // unit size codes
  localparam logic [1:0] UNIT_BYTE = 2'h0;
  localparam logic [1:0] UNIT_HALF = 2'h1;
  localparam logic [1:0] UNIT_WORD = 2'h2;
  // request source codes
  localparam logic [3:0] REQ_EXT_DUAL = 4'h0;
  localparam logic [3:0] REQ_EXT_MEM_TO_DEV = 4'h2;
  localparam logic [3:0] REQ_EXT_DEV_TO_MEM = 4'h3;
  localparam logic [3:0] REQ_AUTO = 4'h4;
  localparam logic [3:0] REQ_PERIPH_FIRST = 4'h6;
  // transfer count that is the last one
  localparam logic [23:0] COUNT_LAST = 24'h00_0001;
  // channel states
  typedef enum logic [1:0] {idle, steal, burst} chan_state_type;
endpackage

// >>> hw/dma_channel_control.sv
`timescale 1ns/1ps
module dma_channel_control
  import dma_channel_pkg::*;
#(
  parameter int chan_index = 0
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic standby,
  input wire logic [7:0] address,
  input wire logic [31:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] read_data,
  input wire logic master_enable,
  input wire logic nmi_abort_flag,
  input wire logic address_error_flag,
  input wire logic ext_request_pin_n,
  input wire logic [9:0] periph_request_n,
  input wire logic unit_done,
  output logic transfer_request,
  output logic transfer_enabled,
  output logic bus_hold_select,
  output logic [1:0] unit_size,
  output logic single_address,
  output logic indirect_mode,
  output logic [31:0] source_address,
  output logic transfer_end_irq
);

  // byte step for one unit, indirect pointer always moves by a word
  function automatic logic [31:0] unit_bytes(input logic [1:0] size,
                                             input logic indirect);
    logic [31:0] result;
    result = 32'h0000_0001;
    case (size)
      UNIT_HALF:
        result = 32'h0000_0002;
      UNIT_WORD:
        result = 32'h0000_0004;
      default:
        result = 32'h0000_0001;
    endcase
    // indirect pointer ignores the unit size
    if (indirect)
      result = 32'h0000_0004;
    return result;
  endfunction

  // true for the three external request codes
  function automatic logic is_ext_code(input logic [3:0] code);
    logic result;
    result = 1'b0;
    if (code == REQ_EXT_DUAL)
      result = 1'b1;
    else if (code == REQ_EXT_MEM_TO_DEV)
      result = 1'b1;
    else if (code == REQ_EXT_DEV_TO_MEM)
      result = 1'b1;
    return result;
  endfunction

  localparam bit ext_capable = (chan_index < 2);
  localparam bit indirect_capable = (chan_index == 3);

  // control fields
  logic [1:0] src_step;
  logic [3:0] request_source_select;
  logic request_sense_select;
  logic done_irq_enable;
  logic count_done_flag;
  logic channel_enable;
  logic done_seen;
  logic [23:0] transfer_count;
  chan_state_type state;

  // external pin synchroniser and filtered level
  logic pin_s1;
  logic pin_s2;
  logic pin_s3;
  logic pin_level;
  logic pin_level_prev;
  logic [9:0] periph_prev;

  // bus decode
  wire control_hit = (address == OFS_CONTROL);
  wire count_hit = (address == OFS_COUNT);
  wire source_hit = (address == OFS_SOURCE);
  wire control_write = write_strobe && control_hit;
  wire count_write = write_strobe && count_hit;
  wire source_write = write_strobe && source_hit;
  wire control_read = read_strobe && control_hit;

  // request source decode
  wire src_is_ext = ext_capable &&
    is_ext_code(request_source_select);
  wire src_is_auto = (request_source_select == REQ_AUTO);
  wire src_is_periph =
    (request_source_select >= REQ_PERIPH_FIRST);
  wire [3:0] periph_index = request_source_select - REQ_PERIPH_FIRST;
  wire dev_to_mem = src_is_ext &&
    (request_source_select == REQ_EXT_DEV_TO_MEM);

  // external sensing: low level or falling edge of the filtered pin
  wire ext_low = !pin_level;
  wire ext_fall = pin_level_prev && !pin_level;
  wire ext_hit = src_is_ext &&
    (request_sense_select ? ext_fall : ext_low);
  // peripheral lines always sensed on a falling edge
  wire [9:0] periph_fall = periph_prev & ~periph_request_n;
  wire periph_hit = src_is_periph &&
    periph_fall[periph_index];

  // channel may transfer only with every gate open
  wire enabled = channel_enable && !count_done_flag && master_enable &&
    !nmi_abort_flag && !address_error_flag;
  wire request_hit = ext_hit || periph_hit;
  wire unit_ok = unit_done && (state != idle) && enabled;
  wire finishing = unit_ok && (transfer_count == COUNT_LAST);

  // source pointer step
  wire hold_source = dev_to_mem && single_address;
  wire indirect_on = indirect_mode && indirect_capable;
  wire [31:0] step = unit_bytes(unit_size, indirect_on);
  wire [31:0] next_source_up = source_address + step;
  wire [31:0] next_source_down = source_address - step;

  // count-done clear: 0 write only after it was read as 1
  wire done_clear = control_write && done_seen &&
    !write_data[POS_DONE];

  // read mux, reserved bits zero
  wire [31:0] control_view = {11'h000, indirect_on, 6'h00, src_step,
    request_source_select, 1'b0, request_sense_select, bus_hold_select,
    unit_size, done_irq_enable, count_done_flag, channel_enable};
  wire [31:0] read_mux = control_hit ? control_view :
    count_hit ? {8'h00, transfer_count} :
    source_hit ? source_address : RST_READ;

  // state after this cycle
  chan_state_type next_state;
  always_comb
  begin
    next_state = state;
    case (state)
      idle:
        if (enabled && (src_is_auto || request_hit))
          next_state = bus_hold_select ? burst : steal;
      steal:
        if (!enabled || unit_ok)
          next_state = idle;
      burst:
        if (!enabled || finishing)
          next_state = idle;
      default:
        next_state = idle;
    endcase
  end

  // external pin: three flops, idle high after reset
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
    end
    else
    begin
      pin_s1 <= ext_request_pin_n;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // filtered level: change taken once second and third agree
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_level <= 1'b1;
      pin_level_prev <= 1'b1;
    end
    else
    begin
      if (pin_s2 == pin_s3)
        pin_level <= pin_s3;
      pin_level_prev <= pin_level;
    end
  end

  // previous peripheral lines, idle high so no false edge after reset
  always_ff @(posedge clk)
  begin
    if (reset)
      periph_prev <= 10'h3ff;
    else
      periph_prev <= periph_request_n;
  end

  // transfer configuration fields
  always_ff @(posedge clk)
  begin
    if (reset || standby)
    begin
      src_step <= RST_SRC_STEP;
      request_source_select <= RST_REQ_SRC;
      request_sense_select <= 1'b0;
      bus_hold_select <= 1'b0;
      unit_size <= RST_UNIT;
      done_irq_enable <= 1'b0;
    end
    else if (control_write)
    begin
      src_step <= write_data[POS_SRC_STEP +: 2];
      request_source_select <= write_data[POS_REQ_SRC +: 4];
      request_sense_select <= ext_capable &&
        write_data[POS_SENSE];
      bus_hold_select <= write_data[POS_BUS_HOLD];
      unit_size <= write_data[POS_UNIT +: 2];
      done_irq_enable <= write_data[POS_IRQ_EN];
    end
  end

  // channel enable and indirect bit, the latter on channel 3 only
  always_ff @(posedge clk)
  begin
    if (reset || standby)
    begin
      channel_enable <= 1'b0;
      indirect_mode <= 1'b0;
    end
    else if (control_write)
    begin
      channel_enable <= write_data[POS_ENABLE];
      indirect_mode <= indirect_capable &&
        write_data[POS_INDIRECT];
    end
  end

  // count-done flag: hardware set wins over software clear
  always_ff @(posedge clk)
  begin
    if (reset || standby)
      count_done_flag <= 1'b0;
    else if (finishing)
      count_done_flag <= 1'b1;
    else if (done_clear)
      count_done_flag <= 1'b0;
  end

  // remembers a read of the flag as 1; any control write clears it
  always_ff @(posedge clk)
  begin
    if (reset || standby)
      done_seen <= 1'b0;
    else if (control_read && count_done_flag)
      done_seen <= 1'b1;
    else if (control_write)
      done_seen <= 1'b0;
  end

  // transfer count: load, or one less per unit
  always_ff @(posedge clk)
  begin
    if (reset || standby)
      transfer_count <= RST_COUNT;
    else if (count_write)
      transfer_count <= write_data[23:0];
    else if (unit_ok)
      transfer_count <= transfer_count - COUNT_LAST;
  end

  // source pointer: load, or step after each unit
  always_ff @(posedge clk)
  begin
    if (reset || standby)
      source_address <= RST_SOURCE;
    else if (source_write)
      source_address <= write_data;
    else if (unit_ok && !hold_source && src_step == STEP_UP)
      source_address <= next_source_up;
    else if (unit_ok && !hold_source && src_step == STEP_DOWN)
      source_address <= next_source_down;
  end

  // sequencer state
  always_ff @(posedge clk)
  begin
    if (reset || standby)
      state <= idle;
    else
      state <= next_state;
  end

  // bus request and enable status
  always_ff @(posedge clk)
  begin
    if (reset || standby)
    begin
      transfer_request <= 1'b0;
      transfer_enabled <= 1'b0;
    end
    else
    begin
      transfer_request <= (next_state != idle) && enabled &&
        !finishing;
      transfer_enabled <= enabled;
    end
  end

  // address mode and completion interrupt
  always_ff @(posedge clk)
  begin
    if (reset || standby)
    begin
      single_address <= 1'b0;
      transfer_end_irq <= 1'b0;
    end
    else
    begin
      single_address <= src_is_ext &&
        request_source_select != REQ_EXT_DUAL;
      transfer_end_irq <= done_irq_enable &&
        (count_done_flag || finishing) && !done_clear;
    end
  end

  // read data stands for one cycle after the strobe, else zero
  always_ff @(posedge clk)
  begin
    if (reset || standby)
      read_data <= RST_READ;
    else
      read_data <= read_strobe ? read_mux : RST_READ;
  end

endmodule

// >>> test/dma_channel_control_checker.sv
`timescale 1ns/1ps
// watches the channel outputs against their causes
module dma_channel_control_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic standby,
  input wire logic write_strobe,
  input wire logic master_enable,
  input wire logic nmi_abort_flag,
  input wire logic address_error_flag,
  input wire logic unit_done,
  input wire logic transfer_request,
  input wire logic transfer_enabled,
  input wire logic bus_hold_select,
  input wire logic transfer_end_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset || standby);
  // named steps of a transfer
  sequence unit_taken;
    transfer_request && unit_done;
  endsequence
  sequence steal_unit;
    unit_taken ##0 !bus_hold_select;
  endsequence
  sequence blocked;
    !master_enable || nmi_abort_flag || address_error_flag;
  endsequence
  a_blocked_disables: assert property (blocked |=> !transfer_enabled)
    else $error("enabled while blocked");
  a_blocked_stops: assert property (blocked |-> ##[1:2] !transfer_request)
    else $error("request kept while blocked");
  a_rise_needs_enable: assert property ($rose(transfer_request) |-> transfer_enabled)
    else $error("request without enable");
  a_stays_enabled: assert property (transfer_request && !unit_done && !write_strobe && !$past(write_strobe) && master_enable && !nmi_abort_flag && !address_error_flag |=> transfer_enabled)
    else $error("enable lost without cause");
  a_steal_drops: assert property (steal_unit |=> !transfer_request)
    else $error("cycle steal kept the bus");
  a_done_halts: assert property (transfer_end_irq |-> !transfer_request)
    else $error("request while done");
  a_irq_cause: assert property ($rose(transfer_end_irq) |-> $past(unit_done) || $past(write_strobe))
    else $error("irq without completion");
  a_irq_holds: assert property (transfer_end_irq && !write_strobe |=> transfer_end_irq)
    else $error("done cleared without write");
endmodule

bind dma_channel_control dma_channel_control_checker chk (
  .clk(clk), .reset(reset), .standby(standby),
  .write_strobe(write_strobe), .master_enable(master_enable),
  .nmi_abort_flag(nmi_abort_flag), .address_error_flag(address_error_flag),
  .unit_done(unit_done), .transfer_request(transfer_request),
  .transfer_enabled(transfer_enabled), .bus_hold_select(bus_hold_select),
  .transfer_end_irq(transfer_end_irq)
);

// >>> test/request_source_model.sv
`timescale 1ns/1ps
// far side: external requester and peripheral event lines
module request_source_model (
  input wire logic clk,
  input wire logic fire_ext,
  input wire logic [9:0] fire_periph,
  output logic ext_request_pin_n,
  output logic [9:0] periph_request_n
);
  logic [3:0] hold = 4'h0;
  initial ext_request_pin_n = 1'b1;
  initial periph_request_n = 10'h3ff;
  // pin idles high (pull-up), low for some cycles per request
  always @(posedge clk)
  begin
    hold <= fire_ext ? 4'h8 : hold - {3'h0, hold != 4'h0};
    ext_request_pin_n <= !(fire_ext || hold > 4'h1);
    periph_request_n <= ~fire_periph;
  end
endmodule

// >>> test/dma_channel_control_tb.sv
`timescale 1ns/1ps
module dma_channel_control_tb;
  import dma_channel_pkg::*;
  logic clk = 0, reset = 1, standby = 0, write_strobe = 0, read_strobe = 0;
  logic master_enable = 0, nmi = 0, aerr = 0, unit_done = 0, fire_e = 0;
  logic rd_now = 0, req, irq, ext_n;
  logic use3 = 0, req3, ind3, single;
  logic [1:0] usize;
  logic [31:0] src3, read3, src_out, e;
  logic [7:0] address = 8'h00;
  logic [9:0] fire_p = 10'h000, per_n;
  logic [31:0] write_data = 32'h0000_0000, src, read_data;
  logic [31:0] seed = 32'h0000_d35a;
  logic [31:0] exp_q[$];
  int bad_count = 0, checks = 0;
  always #20 clk = ~clk;
  dma_channel_control #(.chan_index(0)) uut (
    .clk(clk), .reset(reset), .standby(standby), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data),
    .master_enable(master_enable), .nmi_abort_flag(nmi),
    .address_error_flag(aerr), .ext_request_pin_n(ext_n),
    .periph_request_n(per_n), .unit_done(unit_done),
    .transfer_request(req), .transfer_enabled(), .bus_hold_select(),
    .unit_size(usize), .single_address(single), .indirect_mode(),
    .source_address(src_out), .transfer_end_irq(irq)
  );
  dma_channel_control #(.chan_index(3)) uut3 (
    .clk(clk), .reset(reset), .standby(standby), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read3),
    .master_enable(master_enable), .nmi_abort_flag(nmi),
    .address_error_flag(aerr), .ext_request_pin_n(ext_n),
    .periph_request_n(per_n), .unit_done(unit_done),
    .transfer_request(req3), .transfer_enabled(), .bus_hold_select(),
    .unit_size(), .single_address(), .indirect_mode(ind3),
    .source_address(src3), .transfer_end_irq()
  );
  request_source_model far (.clk(clk), .fire_ext(fire_e),
    .fire_periph(fire_p), .ext_request_pin_n(ext_n),
    .periph_request_n(per_n));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // read words are compared against the oldest note
  always @(posedge clk)
  begin
    if (rd_now) check("read_data", use3 ? read3 : read_data, exp_q.pop_front());
    rd_now <= read_strobe;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    write_data <= d;
    write_strobe <= 1;
    @(posedge clk);
    write_strobe <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    address <= a;
    read_strobe <= 1;
    exp_q.push_back(e);
    @(posedge clk);
    read_strobe <= 0;
  endtask
  task automatic wait_req(input logic v);
    for (int n = 0; n < 50 && req !== v; n++) @(posedge clk);
    if (req !== v)
    begin
      check("request wait", {31'h0, req}, {31'h0, v});
      tally_and_finish();
    end
  endtask
  // one unit with given control bits and request code, then clear done
  task automatic xfer(input logic [31:0] c, input logic [3:0] code);
    wr(OFS_COUNT, 32'h0000_0001);
    wr(OFS_CONTROL, c | (32'(code) << POS_REQ_SRC) | 32'h0000_0001);
    repeat (4) @(posedge clk);
    check("start", {31'h0, req}, {31'h0, code == REQ_AUTO});
    check("start ch3", {31'h0, req3}, {31'h0, code == REQ_AUTO});
    if (code < 4) fire_e <= 1;
    else if (code > 5) fire_p <= 10'h001 << (code - 6);
    @(posedge clk);
    fire_e <= 0;
    fire_p <= 10'h000;
    wait_req(1);
    check("ext ch3", {31'h0, req3}, {31'h0, code > 3});
    unit_done <= 1;
    @(posedge clk);
    unit_done <= 0;
    @(posedge clk);
    check("irq", {31'h0, irq}, {31'h0, c[POS_IRQ_EN]});
    check("size", {30'h0, usize}, {30'h0, c[POS_UNIT +: 2]});
    check("single", {31'h0, single}, {31'h0, code == 2 || code == 3});
    check("halt", {31'h0, req}, 32'h0000_0000);
    rd(OFS_CONTROL, c | (32'(code) << 8) | 32'h0000_0003);
    wr(OFS_CONTROL, 32'h0000_0000);
    rd(OFS_CONTROL, 32'h0000_0000);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 0;
    rd(OFS_CONTROL, RST_READ);
    rd(OFS_COUNT, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    master_enable <= 1;
    seed = lfsr(seed);
    wr(OFS_COUNT, seed);
    rd(OFS_COUNT, {8'h00, seed[23:0]});
    wr(OFS_CONTROL, 32'h0010_0042);
    rd(OFS_CONTROL, 32'h0000_0040);
    $display("test registers done");
    for (int s = 0; s < 3; s++)
      for (int u = 0; u < 3; u++)
      begin
        seed = lfsr(seed);
        src = seed & 32'h00ff_fff0;
        wr(OFS_SOURCE, src);
        xfer((s << POS_SRC_STEP) | (u << POS_UNIT) | 4, REQ_AUTO);
        e = s == 1 ? src + (1 << u) : s == 2 ? src - (1 << u) : src;
        rd(OFS_SOURCE, e);
        check("source out", src_out, e);
      end
    $display("test source steps done");
    for (int c = 0; c < 16; c++)
      if (c != 1 && c != 5)
      begin
        wr(OFS_SOURCE, 32'h0000_0200);
        xfer(32'h0000_1000, 4'(c));
        rd(OFS_SOURCE, c == 3 ? 32'h0000_0200 : 32'h0000_0201);
      end
    $display("test request sources done");
    wr(OFS_COUNT, 32'h0000_0003);
    wr(OFS_CONTROL, 32'h0000_0401);
    wait_req(1);
    nmi <= 1;
    wait_req(0);
    nmi <= 0;
    wait_req(1);
    master_enable <= 0;
    wait_req(0);
    master_enable <= 1;
    wait_req(1);
    wr(OFS_CONTROL, 32'h0000_0400);
    wait_req(0);
    rd(OFS_CONTROL, 32'h0000_0400);
    repeat (3) @(posedge clk);
    $display("test early stop done");
    wr(OFS_COUNT, 32'h0000_0003);
    wr(OFS_CONTROL, 32'h0000_0421);
    wait_req(1);
    unit_done <= 1;
    repeat (2) @(posedge clk);
    check("burst", {31'h0, req}, 32'h0000_0001);
    @(posedge clk);
    unit_done <= 0;
    @(posedge clk);
    check("burst end", {31'h0, req}, 32'h0000_0000);
    rd(OFS_CONTROL, 32'h0000_0423);
    standby <= 1;
    @(posedge clk);
    standby <= 0;
    rd(OFS_CONTROL, 32'h0000_0000);
    $display("test burst and standby done");
    @(posedge clk);
    use3 <= 1;
    wr(OFS_SOURCE, 32'h0000_0100);
    wr(OFS_COUNT, 32'h0000_0001);
    wr(OFS_CONTROL, 32'h0010_1445);
    wait_req(1);
    check("indirect", {31'h0, ind3}, 32'h0000_0001);
    unit_done <= 1;
    @(posedge clk);
    unit_done <= 0;
    @(posedge clk);
    check("indirect step", src3, 32'h0000_0104);
    rd(OFS_CONTROL, 32'h0010_1407);
    repeat (3) @(posedge clk);
    $display("test channel three done");
    tally_and_finish();
  end
endmodule
